// file: ldmfc_pkg.sv
// Purpose: shared constants and types for the led driver mode and fault supervisor
// Assumes: 10 MHz system clock, comparator flags synchronous to clk
// Notes:   all counts in clock cycles unless named otherwise
`default_nettype none

package ldmfc_pkg;

    // ========================================================================
    // clock and timing
    // ========================================================================
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned SS_DISCH_NS     = 1000;  // least soft-start discharge time
    localparam int unsigned SS_DISCH_CYC_I  = (SS_DISCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [7:0]  SS_DISCH_CYC    = 8'(SS_DISCH_CYC_I < 1 ? 1 : SS_DISCH_CYC_I);

    // ========================================================================
    // widths and reset values
    // ========================================================================
    localparam int unsigned N_STRINGS       = 4;
    localparam int unsigned DAC_W           = 8;
    localparam int unsigned ADC_W           = 7;
    localparam logic [7:0]  REF_RST         = 8'hff;  // full scale is the 1.25 V reference
    localparam logic [7:0]  ISET_RST        = 8'h00;  // lowest string current after reset
    localparam logic [6:0]  ADC_RST         = 7'h00;
    localparam logic [6:0]  SHORT_LIM_RST   = 7'h60;  // drain above this suggests shorted leds
    localparam logic [6:0]  OPEN_LIM_RST    = 7'h02;  // drain below this suggests open string

    // ========================================================================
    // operating states, gray coded along the listed order from normal to overvoltage
    // ========================================================================
    typedef enum logic [2:0] {
        LDMFC_NORMAL         = 3'h0,
        LDMFC_LOW_SUPPLY     = 3'h1,
        LDMFC_OVERHEAT       = 3'h3,
        LDMFC_PIN_OFF        = 3'h2,
        LDMFC_SERIAL_SLEEP   = 3'h6,
        LDMFC_OVERVOLTAGE    = 3'h7
    } ldmfc_state_e;

endpackage

`default_nettype wire

// file: ldmfc_string_mon.sv
// Purpose: per-string drain sample store and short/open flags
// Assumes: adc samples arrive with a one-cycle strobe and a string index
// Notes:   read data and flags come straight from registers
`default_nettype none

module ldmfc_string_mon #(
    parameter int unsigned N_STR = 4,
    parameter int unsigned AW    = 7
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      ce,
    // sample write side
    input  wire logic                      smp_valid,
    input  wire logic [1:0]                smp_idx,
    input  wire logic [AW-1:0]             smp_data,
    // limits
    input  wire logic [AW-1:0]             short_lim,
    input  wire logic [AW-1:0]             open_lim,
    // read side
    input  wire logic [1:0]                rd_idx,
    output var  logic [AW-1:0]             rd_data_q,
    output var  logic [N_STR-1:0]          short_q,
    output var  logic [N_STR-1:0]          open_q
);

    // ========================================================================
    // sample store
    // ========================================================================
    logic [AW-1:0] mem_q [N_STR];

    // one entry per string, flags follow the last stored sample
    genvar g;
    generate
        for (g = 0; g < N_STR; g++) begin : g_str
            wire hit = smp_valid && (smp_idx == 2'(g));
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    mem_q[g]   <= ldmfc_pkg::ADC_RST;
                    short_q[g] <= 1'b0;
                    open_q[g]  <= 1'b0;
                end else if (ce && hit) begin
                    mem_q[g]   <= smp_data;
                    short_q[g] <= smp_data > short_lim;
                    open_q[g]  <= smp_data < open_lim;
                end
            end
        end
    endgenerate

    // registered read port
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_q <= ldmfc_pkg::ADC_RST;
        end else if (ce) begin
            rd_data_q <= mem_q[rd_idx];
        end
    end

endmodule

`default_nettype wire

// file: ldmfc_top.sv
// Purpose: mode and fault supervisor for a four-string led driver
// Assumes: comparator flags, enable pin and serial commands synchronous to clk
// Notes:   serial decoding lives outside; commands reach this block as strobes
//
// Summary of operation
// - six states: normal, low supply, overheat, pin off, serial sleep, overvoltage
// - normal is default; all string sinks regulate
// - low supply flag disables sinks and regulator until it clears
// - overheat flag disables sinks and regulator until the die cools
// - enable low gives pin off; high leaves it, a clocked enable re-enters it on each low phase
// - serial sleep entered and left by serial command only; sinks, regulator off
// - entering any regulator-off state discharges soft-start
// - overvoltage latches gate drive off; cleared by enable toggle, power, or sleep
// - primary current limit ends the on-time for the rest of the cycle
// - gross current limit ends the cycle, discharges soft-start, restarts
// - feedback reference defaults to full scale, host may lower it
// - host sets string currents and output voltage, reads drain samples
// - drain samples expose shorted and open strings to the host
`default_nettype none

module ldmfc_top #(
    parameter int unsigned N_STR = ldmfc_pkg::N_STRINGS,
    parameter int unsigned DW    = ldmfc_pkg::DAC_W,
    parameter int unsigned AW    = ldmfc_pkg::ADC_W
) (
    // clock, reset, enable
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // pins and comparator flags
    input  wire logic                 sync_en,
    input  wire logic                 supply_low,
    input  wire logic                 over_temp,
    input  wire logic                 ovp_cmp,
    input  wire logic                 ilim_pri,
    input  wire logic                 ilim_gross,
    input  wire logic                 pwm_on,
    input  wire logic                 cycle_start,
    // serial commands
    input  wire logic                 sleep_set,
    input  wire logic                 sleep_clr,
    input  wire logic                 iset_wr,
    input  wire logic [1:0]           iset_idx,
    input  wire logic [DW-1:0]        iset_data,
    input  wire logic                 ref_wr,
    input  wire logic [DW-1:0]        ref_data,
    input  wire logic [1:0]           drain_rd_idx,
    input  wire logic [AW-1:0]        short_lim,
    input  wire logic [AW-1:0]        open_lim,
    // adc samples
    input  wire logic                 adc_valid,
    input  wire logic [1:0]           adc_idx,
    input  wire logic [AW-1:0]        adc_data,
    // outputs
    output var  logic                 switch_gate_drive_q,
    output var  logic [N_STR-1:0]     sink_en_q,
    output var  logic                 ss_discharge_q,
    output var  logic                 vcc_reg_en_q,
    output var  logic [2:0]           state_q,
    output var  logic                 ovp_latched_q,
    output var  logic [DW-1:0]        fb_ref_q,
    output var  logic [N_STR*DW-1:0]  iset_q,
    output var  logic [AW-1:0]        drain_rd_q,
    output var  logic [N_STR-1:0]     short_q,
    output var  logic [N_STR-1:0]     open_q
);

    // ========================================================================
    // internal registers
    // ========================================================================
    logic                    sleep_q;       // serial sleep held
    logic                    sleep_d;
    logic                    ovp_d;
    logic                    cut_q;         // on-time cut for this cycle
    logic                    cut_d;
    logic [7:0]              disch_cnt_q;   // soft-start discharge timer
    logic [7:0]              disch_cnt_d;
    logic                    run_d;         // regulator and sinks allowed
    logic                    vcc_d;         // gate-drive supply allowed
    logic                    gate_d;
    ldmfc_pkg::ldmfc_state_e state_d;

    // ========================================================================
    // request decode
    // ========================================================================
    // fault and mode requests as named wires
    wire logic pin_off_req = !sync_en;
    wire logic low_req     = supply_low;
    wire logic heat_req    = over_temp;
    wire logic disch_busy  = (disch_cnt_q != 8'h00);

    // sleep follows serial strobes only; set wins a tie
    assign sleep_d = sleep_set || (sleep_q && !sleep_clr);

    // overvoltage latch: set by the comparator while enabled and awake,
    // cleared by enable low or by serial sleep
    wire logic ovp_set = ovp_cmp && sync_en && !sleep_d;
    wire logic ovp_clr = !sync_en || sleep_d;
    assign ovp_d = ovp_set || (ovp_latched_q && !ovp_clr);

    // ========================================================================
    // operating state
    // ========================================================================
    // priority: pin off, low supply, overheat, sleep, overvoltage, normal
    assign state_d = pin_off_req ? ldmfc_pkg::LDMFC_PIN_OFF      :
                     low_req     ? ldmfc_pkg::LDMFC_LOW_SUPPLY   :
                     heat_req    ? ldmfc_pkg::LDMFC_OVERHEAT     :
                     sleep_d     ? ldmfc_pkg::LDMFC_SERIAL_SLEEP :
                     ovp_d       ? ldmfc_pkg::LDMFC_OVERVOLTAGE  :
                                   ldmfc_pkg::LDMFC_NORMAL;

    // what each state allows
    always_comb begin
        run_d = 1'b0;
        vcc_d = 1'b1;
        case (state_d)
            ldmfc_pkg::LDMFC_NORMAL: begin
                run_d = 1'b1;
            end
            ldmfc_pkg::LDMFC_LOW_SUPPLY: begin
                vcc_d = 1'b1;
            end
            ldmfc_pkg::LDMFC_OVERHEAT: begin
                vcc_d = 1'b0;
            end
            ldmfc_pkg::LDMFC_PIN_OFF: begin
                vcc_d = 1'b0;
            end
            ldmfc_pkg::LDMFC_SERIAL_SLEEP: begin
                vcc_d = 1'b1;
            end
            ldmfc_pkg::LDMFC_OVERVOLTAGE: begin
                vcc_d = 1'b1;
            end
            default: begin
                run_d = 1'b0;
                vcc_d = 1'b0;
            end
        endcase
    end

    // ========================================================================
    // regulator control
    // ========================================================================
    // either limit cuts the on-time until the next cycle start; set wins
    assign cut_d = ilim_pri || ilim_gross || (cut_q && !cycle_start);

    // discharge timer reloads while off or on a gross limit, then counts out,
    // so the regulator always comes back through a fresh soft-start
    assign disch_cnt_d = (!run_d || ilim_gross) ? ldmfc_pkg::SS_DISCH_CYC :
                         disch_busy             ? disch_cnt_q - 8'h01     :
                                                  8'h00;

    // gate drive only when running, not cut and soft-start released
    assign gate_d = run_d && pwm_on && !cut_d && (disch_cnt_d == 8'h00);

    // ========================================================================
    // output decode
    // ========================================================================
    // sinks follow the run permission as one group
    wire logic [N_STR-1:0] sink_d  = {N_STR{run_d}};
    // discharge stands while the timer is loaded
    wire logic             disch_d = (disch_cnt_d != 8'h00);

    // ========================================================================
    // registers
    // ========================================================================
    // operating state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ldmfc_pkg::LDMFC_NORMAL;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    // serial sleep flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleep_q <= 1'b0;
        end else if (ce) begin
            sleep_q <= sleep_d;
        end
    end

    // overvoltage latch, cleared by power cycling through reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovp_latched_q <= 1'b0;
        end else if (ce) begin
            ovp_latched_q <= ovp_d;
        end
    end

    // on-time cut
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cut_q <= 1'b0;
        end else if (ce) begin
            cut_q <= cut_d;
        end
    end

    // soft-start discharge timer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            disch_cnt_q <= 8'h00;
        end else if (ce) begin
            disch_cnt_q <= disch_cnt_d;
        end
    end

    // soft-start discharge output
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ss_discharge_q <= 1'b0;
        end else if (ce) begin
            ss_discharge_q <= disch_d;
        end
    end

    // switching gate drive
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            switch_gate_drive_q <= 1'b0;
        end else if (ce) begin
            switch_gate_drive_q <= gate_d;
        end
    end

    // string sink enables
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sink_en_q <= '0;
        end else if (ce) begin
            sink_en_q <= sink_d;
        end
    end

    // gate-drive supply regulator enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vcc_reg_en_q <= 1'b0;
        end else if (ce) begin
            vcc_reg_en_q <= vcc_d;
        end
    end

    // feedback reference, full scale after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fb_ref_q <= DW'(ldmfc_pkg::REF_RST);
        end else if (ce && ref_wr) begin
            fb_ref_q <= ref_data;
        end
    end

    // ========================================================================
    // string current settings
    // ========================================================================
    // one setting per string, written by index
    genvar g;
    generate
        for (g = 0; g < N_STR; g++) begin : g_iset
            wire logic hit = iset_wr && (iset_idx == 2'(g));
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    iset_q[g*DW +: DW] <= DW'(ldmfc_pkg::ISET_RST);
                end else if (ce && hit) begin
                    iset_q[g*DW +: DW] <= iset_data;
                end
            end
        end
    endgenerate

    // ========================================================================
    // drain samples
    // ========================================================================
    // sample store, readback and short/open flags
    ldmfc_string_mon #(
        .N_STR (N_STR),
        .AW    (AW)
    ) ldmfc_string_mon_i (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .smp_valid (adc_valid),
        .smp_idx   (adc_idx),
        .smp_data  (adc_data),
        .short_lim (short_lim),
        .open_lim  (open_lim),
        .rd_idx    (drain_rd_idx),
        .rd_data_q (drain_rd_q),
        .short_q   (short_q),
        .open_q    (open_q)
    );

endmodule

`default_nettype wire

// file: ldmfc_checker.sv
// Purpose: port assertions for the led driver mode supervisor
// Assumes: flags synchronous to clk; Notes: bound after the module
`default_nettype none
module ldmfc_checker (
    // clock, reset and flags
    input wire logic       clk, rst, sync_en, supply_low, over_temp, ovp_cmp, ilim_pri, ilim_gross,
    // watched outputs
    input wire logic       switch_gate_drive_q, ss_discharge_q, ovp_latched_q,
    input wire logic [3:0] sink_en_q,
    input wire logic [2:0] state_q,
    input wire logic [7:0] fb_ref_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // faults held for three cycles
    sequence low_held; supply_low [*3]; endsequence
    sequence heat_held; over_temp [*3]; endsequence
    a_low_supply_off: assert property (low_held |-> !switch_gate_drive_q && sink_en_q == 4'h0)
        else $error("outputs on in low supply");
    a_overheat_off: assert property (heat_held |-> !switch_gate_drive_q && sink_en_q == 4'h0)
        else $error("outputs on in overheat");
    a_pin_off_wins: assert property (!sync_en [*3] |-> state_q == ldmfc_pkg::LDMFC_PIN_OFF)
        else $error("pin low without pin off state");
    a_sleep_off: assert property (state_q == 3'h6 |-> !switch_gate_drive_q && sink_en_q == 4'h0)
        else $error("outputs on in serial sleep");
    a_ovp_gate_off: assert property ($rose(ovp_cmp) && sync_en && state_q != 3'h6 |-> ##[1:3] ovp_latched_q && !switch_gate_drive_q)
        else $error("overvoltage not latched");
    a_ilim_cut: assert property (ilim_pri |-> ##[1:2] !switch_gate_drive_q)
        else $error("gate on after current limit");
    a_gross_disch: assert property ($rose(ilim_gross) |-> ##[0:3] ss_discharge_q)
        else $error("no discharge on gross limit");
    a_leave_disch: assert property ($past(state_q) == 3'h0 && state_q != 3'h0 |-> ##[0:3] ss_discharge_q)
        else $error("no discharge on regulator off");
    a_ref_default: assert property ($fell(rst) |-> fb_ref_q == ldmfc_pkg::REF_RST)
        else $error("reference not full scale");
    a_state_legal: assert property (state_q inside {3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7})
        else $error("illegal state code");
endmodule
bind ldmfc_top ldmfc_checker chk_i (.*);
`default_nettype wire

// file: ldmfc_host_model.sv
// Purpose: serial host issuing command strobes; Notes: data inverted when idle
`default_nettype none
module ldmfc_host_model (
    input  wire logic       clk,
    output var  logic       sleep_set, sleep_clr, ref_wr, iset_wr,
    output var  logic [1:0] iset_idx,
    output var  logic [7:0] ref_data, iset_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {sleep_set, sleep_clr, ref_wr, iset_wr, iset_idx, ref_data, iset_data} = '0;
    // one-cycle command strobe launched after a falling edge
    task automatic cmd(input int k, input logic [1:0] idx, input logic [7:0] d);
        @(negedge clk);
        {iset_idx, ref_data, iset_data} = {idx, d, d};
        sleep_set = (k == 0);
        sleep_clr = (k == 1);
        ref_wr = (k == 2);
        iset_wr = (k == 3);
        @(negedge clk);
        {sleep_set, sleep_clr, ref_wr, iset_wr, ref_data, iset_data} = {4'h0, ~d, ~d};
    endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Purpose: directed mode and fault tests; Assumes: 100 ns clock
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, sync_en = 1, supply_low = 0, over_temp = 0, ovp_cmp = 0, ilim_pri = 0, ilim_gross = 0;
    logic adc_valid = 0, sleep_set, sleep_clr, ref_wr, iset_wr, switch_gate_drive_q, ss_discharge_q;
    logic vcc_reg_en_q, ovp_latched_q, cycle_start = 0;
    logic [1:0] adc_idx = 2'h0, iset_idx;
    logic [6:0] adc_data = 7'h00, drain_rd_q;
    logic [7:0] ref_data, iset_data, fb_ref_q;
    logic [3:0] sink_en_q, short_q, open_q;
    logic [2:0] state_q;
    logic [31:0] iset_q;
    int fails = 0, checks_done = 0;
    always #50 clk = ~clk;
    ldmfc_host_model ldmfc_host_model_i (.*);
    ldmfc_top ldmfc_top_i (.*, .ce(1'b1), .pwm_on(1'b1), .drain_rd_idx(adc_idx),
        .short_lim(ldmfc_pkg::SHORT_LIM_RST), .open_lim(ldmfc_pkg::OPEN_LIM_RST));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int n); repeat (n) @(negedge clk); endtask
    // raise a fault flag, check state and outputs off, drop it
    task automatic flt(ref logic f, input logic [2:0] st);
        f = 1;
        wait_n(4);
        chk(state_q, st);
        chk({switch_gate_drive_q, sink_en_q}, 32'h0);
        f = 0;
        wait_n(4);
        $display("test fault %h done", st);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #50us;
        fails++;
        stop_test;
    end
    initial begin
        wait_n(16);
        rst = 0;
        wait_n(4);
        chk(state_q, ldmfc_pkg::LDMFC_NORMAL);
        chk(fb_ref_q, ldmfc_pkg::REF_RST);
        chk(switch_gate_drive_q, 1'b1);
        $display("test reset defaults done");
        flt(supply_low, ldmfc_pkg::LDMFC_LOW_SUPPLY);
        flt(over_temp, ldmfc_pkg::LDMFC_OVERHEAT);
        flt(ovp_cmp, ldmfc_pkg::LDMFC_OVERVOLTAGE);
        ldmfc_host_model_i.cmd(0, 2'h0, 8'h00);
        wait_n(3);
        chk(state_q, ldmfc_pkg::LDMFC_SERIAL_SLEEP);
        chk(ovp_latched_q, 1'b0);
        chk(vcc_reg_en_q, 1'b1);
        ldmfc_host_model_i.cmd(1, 2'h0, 8'h00);
        wait_n(3);
        chk(state_q, ldmfc_pkg::LDMFC_NORMAL);
        ovp_cmp = 1;
        wait_n(3);
        ovp_cmp = 0;
        sync_en = 0;
        supply_low = 1;
        wait_n(4);
        chk(state_q, ldmfc_pkg::LDMFC_PIN_OFF);
        chk(vcc_reg_en_q, 1'b0);
        sync_en = 1;
        supply_low = 0;
        wait_n(4);
        chk({ovp_latched_q, state_q}, 32'h0);
        ldmfc_host_model_i.cmd(2, 2'h0, 8'h80);
        ldmfc_host_model_i.cmd(3, 2'h2, 8'h5a);
        {adc_valid, adc_idx, adc_data} = {1'b1, 2'h1, 7'h70};
        wait_n(1);
        adc_valid = 0;
        wait_n(3);
        chk(fb_ref_q, 8'h80);
        chk(iset_q[23:16], 8'h5a);
        chk({drain_rd_q, short_q[1]}, 8'he1);
        {adc_valid, adc_idx, adc_data} = {1'b1, 2'h2, 7'h01};
        wait_n(1);
        adc_valid = 0;
        wait_n(3);
        chk({open_q, short_q}, 8'h42);
        {ilim_pri, ilim_gross} = 2'h3;
        wait_n(1);
        {ilim_pri, ilim_gross} = 2'h0;
        wait_n(20);
        chk(state_q, ldmfc_pkg::LDMFC_NORMAL);
        chk(switch_gate_drive_q, 1'b0);
        cycle_start = 1;
        wait_n(1);
        cycle_start = 0;
        wait_n(2);
        chk(switch_gate_drive_q, 1'b1);
        $display("test serial and limits done");
        stop_test;
    end
endmodule
`default_nettype wire
